// file: core/ppc_port_options.sv
// Per-port pin option store with read address latch
`timescale 1ns/100ps
`default_nettype none
module ppc_port_options (
  input  wire logic                  clk_i,
  input  wire logic                  rst_i,
  ppc_opt_if.store                   opt,
  output logic [7:0][2:0]            out_mode_o,
  output logic [7:0][1:0]            in_mode_o
);
  import ppc_pkg::*;

  // ==========================================================================
  // State
  logic [7:0][2:0] out_mode;
  logic [7:0][1:0] in_mode;
  logic [2:0]      rd_pin;
  logic            rd_input;
  logic [7:0][2:0] next_out_mode;
  logic [7:0][1:0] next_in_mode;
  logic [2:0]      next_rd_pin;
  logic            next_rd_input;
  logic [2:0]      wpin;

  assign wpin = opt.wdata[PIN_HI:PIN_LO];

  always_comb begin
    next_out_mode = out_mode;
    next_in_mode  = in_mode;
    next_rd_pin   = rd_pin;
    next_rd_input = rd_input;
    if (opt.wr) begin
      if (opt.wdata[RADDR_BIT]) begin
        next_rd_pin   = wpin;
        next_rd_input = opt.wdata[INPUT_SEL];
      end else if (opt.wdata[INPUT_SEL]) begin
        next_in_mode[wpin] = opt.wdata[MODE_LO+1:MODE_LO];
      end else begin
        next_out_mode[wpin] = opt.wdata[MODE_HI:MODE_LO];
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      out_mode <= '0;
      in_mode  <= '0;
      rd_pin   <= PIN_RESET;
      rd_input <= 1'b0;
    end else begin
      out_mode <= next_out_mode;
      in_mode  <= next_in_mode;
      rd_pin   <= next_rd_pin;
      rd_input <= next_rd_input;
    end
  end

  // Readback of the latched pin and option type
  assign opt.rdata = rd_input ? {1'b0, in_mode[rd_pin]} : out_mode[rd_pin];
  assign out_mode_o = out_mode;
  assign in_mode_o  = in_mode;

  // ==========================================================================
  // Checks
  a_raddr_no_change: assert property (@(posedge clk_i) disable iff (rst_i)
    opt.wr && opt.wdata[RADDR_BIT] |=> $stable(out_mode) && $stable(in_mode))
    else $error("Read address write changed a pin mode");
  a_out_update: assert property (@(posedge clk_i) disable iff (rst_i)
    opt.wr && !opt.wdata[RADDR_BIT] && !opt.wdata[INPUT_SEL]
    |=> out_mode[$past(wpin)] == $past(opt.wdata[MODE_HI:MODE_LO]) && $stable(in_mode))
    else $error("Output mode not updated");
  a_in_update: assert property (@(posedge clk_i) disable iff (rst_i)
    opt.wr && !opt.wdata[RADDR_BIT] && opt.wdata[INPUT_SEL]
    |=> in_mode[$past(wpin)] == $past(opt.wdata[MODE_LO+1:MODE_LO]) && $stable(out_mode))
    else $error("Input mode not updated");
endmodule
`default_nettype wire

// file: core/ppc_top.sv
// Port direction and pin option registers behind an APB slave
`timescale 1ns/100ps
`default_nettype none

module ppc_top (
  input  wire logic                            clk_i,
  input  wire logic                            rst_i,
  input  wire logic                            psel_i,
  input  wire logic                            penable_i,
  input  wire logic                            pwrite_i,
  input  wire logic [ppc_pkg::PAW-1:0]         paddr_i,
  input  wire logic [31:0]                     pwdata_i,
  output logic [31:0]                          prdata_o,
  output logic                                 pready_o,
  output logic                                 pslverr_o,
  output logic [ppc_pkg::NUM_PORTS-1:0][7:0]   pin_oe_o,
  output logic [ppc_pkg::NUM_PORTS-1:0][7:0]   pin_high_drive_o,
  output logic [ppc_pkg::NUM_PORTS-1:0][7:0]   pin_pull_up_o,
  output logic [ppc_pkg::NUM_PORTS-1:0][7:0]   pin_pull_down_o,
  output logic [ppc_pkg::NUM_PORTS-1:0][7:0]   pin_in_buf_en_o
);
  import ppc_pkg::*;

  // ==========================================================================
  // Address decode
  function automatic logic [PAW-1:0] byte_addr(input logic [7:0] idx);
    byte_addr = {2'b00, idx, 2'b00};
  endfunction

  function automatic logic [7:0] port_mask(input int p);
    port_mask = (p == 3) ? ~(8'h01 << P3_RSVD) : 8'hff;
  endfunction

  logic [NUM_PORTS-1:0] dir_hit;
  logic [NUM_PORTS-1:0] opt_hit;
  logic                 any_hit;
  logic                 access;
  logic                 wr_access;

  assign access    = psel_i && penable_i;
  assign wr_access = access && pwrite_i;

  always_comb begin
    dir_hit[0] = paddr_i == byte_addr(PORT0_DIRECTION_IDX);
    dir_hit[1] = paddr_i == byte_addr(PORT1_DIRECTION_IDX);
    dir_hit[2] = paddr_i == byte_addr(PORT2_DIRECTION_IDX);
    dir_hit[3] = paddr_i == byte_addr(PORT3_DIRECTION_IDX);
    opt_hit[0] = paddr_i == byte_addr(PORT0_PIN_OPTIONS_IDX);
    opt_hit[1] = paddr_i == byte_addr(PORT1_PIN_OPTIONS_IDX);
    opt_hit[2] = paddr_i == byte_addr(PORT2_PIN_OPTIONS_IDX);
    opt_hit[3] = paddr_i == byte_addr(PORT3_PIN_OPTIONS_IDX);
  end

  assign any_hit = |{dir_hit, opt_hit};

  // ==========================================================================
  // Per-port direction registers and option stores
  logic [NUM_PORTS-1:0][7:0]      dir;
  logic [NUM_PORTS-1:0][7:0]      next_dir;
  logic [NUM_PORTS-1:0][2:0]      opt_rd;
  logic [NUM_PORTS-1:0][7:0][2:0] out_mode;
  logic [NUM_PORTS-1:0][7:0][1:0] in_mode;

  always_comb begin
    next_dir = dir;
    for (int p = 0; p < NUM_PORTS; p++) begin
      if (wr_access && dir_hit[p]) begin
        next_dir[p] = pwdata_i[7:0] & port_mask(p);
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      for (int p = 0; p < NUM_PORTS; p++) begin
        dir[p] <= DIR_RESET & port_mask(p);
      end
    end else begin
      dir <= next_dir;
    end
  end

  genvar g;
  generate
    for (g = 0; g < NUM_PORTS; g++) begin : g_port
      ppc_opt_if opt ();
      assign opt.wr    = wr_access && opt_hit[g];
      assign opt.wdata = pwdata_i[7:0];
      assign opt_rd[g] = opt.rdata;
      ppc_port_options u_opt (
        .clk_i      (clk_i),
        .rst_i      (rst_i),
        .opt        (opt.store),
        .out_mode_o (out_mode[g]),
        .in_mode_o  (in_mode[g])
      );
      // Pin control from direction and stored modes
      for (genvar b = 0; b < 8; b++) begin : g_bit
        always_comb begin
          pin_oe_o[g][b]         = (g == 3 && b == P3_RSVD) ? 1'b0 : ~dir[g][b];
          pin_high_drive_o[g][b] = out_mode[g][b] == OUT_HIGH;
          pin_pull_up_o[g][b]    = in_mode[g][b] == IN_PULL_UP;
          pin_pull_down_o[g][b]  = in_mode[g][b] == IN_PULL_DOWN;
          pin_in_buf_en_o[g][b]  = in_mode[g][b] != IN_BUF_OFF;
        end
      end
    end
  endgenerate

  // ==========================================================================
  // Read data register
  logic [31:0] rdata;
  logic [31:0] next_rdata;

  always_comb begin
    next_rdata = rdata;
    if (psel_i && !penable_i && !pwrite_i) begin
      next_rdata = '0;
      for (int p = 0; p < NUM_PORTS; p++) begin
        if (dir_hit[p]) begin
          next_rdata[7:0] = dir[p];
        end
        if (opt_hit[p]) begin
          next_rdata[MODE_HI:MODE_LO] = opt_rd[p];
        end
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rdata <= '0;
    end else begin
      rdata <= next_rdata;
    end
  end

  assign prdata_o  = rdata;
  assign pready_o  = 1'b1;
  assign pslverr_o = access && !any_hit;

  // ==========================================================================
  // Checks
  a_dir_reset_input: assert property (@(posedge clk_i)
    rst_i |=> pin_oe_o == '0)
    else $error("Pins not inputs after reset");
  a_dir_write: assert property (@(posedge clk_i) disable iff (rst_i)
    wr_access && dir_hit[2] |=> pin_oe_o[2] == ~$past(pwdata_i[7:0]))
    else $error("Port 2 direction write wrong");
  a_p3_reserved: assert property (@(posedge clk_i) disable iff (rst_i)
    1'b1 |-> !pin_oe_o[3][P3_RSVD] && !dir[3][P3_RSVD])
    else $error("Port 3 bit 7 not reserved");
  a_opt_rd_zero: assert property (@(posedge clk_i) disable iff (rst_i)
    access && !pwrite_i && |opt_hit |-> prdata_o[4:0] == '0 && prdata_o[31:8] == '0)
    else $error("Write-only option bits read nonzero");
  a_unmapped_err: assert property (@(posedge clk_i) disable iff (rst_i)
    access && any_hit |-> !pslverr_o)
    else $error("Mapped access flagged as error");

  // ==========================================================================
  // Register, bus and pin checks, some repeated per port
  a_dir_write_p0: assert property (@(posedge clk_i) disable iff (rst_i)
    wr_access && dir_hit[0] |=> pin_oe_o[0] == ~$past(pwdata_i[7:0]))
    else $error("Port 0 direction write wrong");

  a_dir_write_p1: assert property (@(posedge clk_i) disable iff (rst_i)
    wr_access && dir_hit[1] |=> pin_oe_o[1] == ~$past(pwdata_i[7:0]))
    else $error("Port 1 direction write wrong");

  a_dir_write_p3: assert property (@(posedge clk_i) disable iff (rst_i)
    wr_access && dir_hit[3] |=> pin_oe_o[3] == (~$past(pwdata_i[7:0]) & port_mask(3)))
    else $error("Port 3 direction write wrong");

  a_dir_hold: assert property (@(posedge clk_i) disable iff (rst_i)
    !(wr_access && |dir_hit) |=> $stable(dir))
    else $error("Direction changed without a write");

  a_oe_p3_follow: assert property (@(posedge clk_i) disable iff (rst_i)
    1'b1 |-> pin_oe_o[3][6:0] == ~dir[3][6:0])
    else $error("Port 3 enables do not follow direction");

  a_dir_reset_value: assert property (@(posedge clk_i)
    rst_i |=> dir[0] == DIR_RESET && dir[3] == (DIR_RESET & port_mask(3)))
    else $error("Direction reset value wrong");

  a_pready_high: assert property (@(posedge clk_i) disable iff (rst_i)
    access |-> pready_o)
    else $error("Access phase without ready");

  a_err_unmapped: assert property (@(posedge clk_i) disable iff (rst_i)
    access && !any_hit |-> pslverr_o)
    else $error("Unmapped access not flagged");

  a_err_idle: assert property (@(posedge clk_i) disable iff (rst_i)
    !access |-> !pslverr_o)
    else $error("Error flagged outside access");

  a_rd_dir_p0: assert property (@(posedge clk_i) disable iff (rst_i)
    psel_i && !penable_i && !pwrite_i && dir_hit[0] |=> prdata_o == {24'h0, $past(dir[0])})
    else $error("Port 0 direction read wrong");

  a_rd_dir_p1: assert property (@(posedge clk_i) disable iff (rst_i)
    psel_i && !penable_i && !pwrite_i && dir_hit[1] |=> prdata_o == {24'h0, $past(dir[1])})
    else $error("Port 1 direction read wrong");

  a_rd_dir_p2: assert property (@(posedge clk_i) disable iff (rst_i)
    psel_i && !penable_i && !pwrite_i && dir_hit[2] |=> prdata_o == {24'h0, $past(dir[2])})
    else $error("Port 2 direction read wrong");

  a_rd_dir_p3: assert property (@(posedge clk_i) disable iff (rst_i)
    psel_i && !penable_i && !pwrite_i && dir_hit[3] |=> prdata_o == {24'h0, $past(dir[3])})
    else $error("Port 3 direction read wrong");

  a_rd_upper_zero: assert property (@(posedge clk_i) disable iff (rst_i)
    1'b1 |-> prdata_o[31:8] == '0)
    else $error("Read data upper bits nonzero");

  a_rd_hold: assert property (@(posedge clk_i) disable iff (rst_i)
    !(psel_i && !penable_i && !pwrite_i) |=> $stable(prdata_o))
    else $error("Read data changed without a read");

  a_rd_unmapped: assert property (@(posedge clk_i) disable iff (rst_i)
    psel_i && !penable_i && !pwrite_i && !any_hit |=> prdata_o == '0)
    else $error("Unmapped read not zero");

  a_rd_opt_p0: assert property (@(posedge clk_i) disable iff (rst_i)
    psel_i && !penable_i && !pwrite_i && opt_hit[0]
    |=> prdata_o == {24'h0, $past(opt_rd[0]), 5'h00})
    else $error("Port 0 option read wrong");

  a_rd_opt_p1: assert property (@(posedge clk_i) disable iff (rst_i)
    psel_i && !penable_i && !pwrite_i && opt_hit[1]
    |=> prdata_o == {24'h0, $past(opt_rd[1]), 5'h00})
    else $error("Port 1 option read wrong");

  a_rd_opt_p2: assert property (@(posedge clk_i) disable iff (rst_i)
    psel_i && !penable_i && !pwrite_i && opt_hit[2]
    |=> prdata_o == {24'h0, $past(opt_rd[2]), 5'h00})
    else $error("Port 2 option read wrong");

  a_rd_opt_p3: assert property (@(posedge clk_i) disable iff (rst_i)
    psel_i && !penable_i && !pwrite_i && opt_hit[3]
    |=> prdata_o == {24'h0, $past(opt_rd[3]), 5'h00})
    else $error("Port 3 option read wrong");

  a_pull_exclusive: assert property (@(posedge clk_i) disable iff (rst_i)
    1'b1 |-> (pin_pull_up_o & pin_pull_down_o) == '0)
    else $error("Pull up and pull down together");

  a_buf_off_no_pull: assert property (@(posedge clk_i) disable iff (rst_i)
    1'b1 |-> ((pin_pull_up_o | pin_pull_down_o) & ~pin_in_buf_en_o) == '0)
    else $error("Pull with input buffer off");

  a_out_write_p0: assert property (@(posedge clk_i) disable iff (rst_i)
    wr_access && opt_hit[0] && !pwdata_i[RADDR_BIT] && !pwdata_i[INPUT_SEL]
    |=> out_mode[0][$past(pwdata_i[PIN_HI:PIN_LO])] == $past(pwdata_i[MODE_HI:MODE_LO]))
    else $error("Port 0 output mode not stored");

  a_out_write_p2: assert property (@(posedge clk_i) disable iff (rst_i)
    wr_access && opt_hit[2] && !pwdata_i[RADDR_BIT] && !pwdata_i[INPUT_SEL]
    |=> out_mode[2][$past(pwdata_i[PIN_HI:PIN_LO])] == $past(pwdata_i[MODE_HI:MODE_LO]))
    else $error("Port 2 output mode not stored");

  a_in_write_p1: assert property (@(posedge clk_i) disable iff (rst_i)
    wr_access && opt_hit[1] && !pwdata_i[RADDR_BIT] && pwdata_i[INPUT_SEL]
    |=> in_mode[1][$past(pwdata_i[PIN_HI:PIN_LO])] == $past(pwdata_i[MODE_LO+1:MODE_LO]))
    else $error("Port 1 input mode not stored");

  a_in_write_p3: assert property (@(posedge clk_i) disable iff (rst_i)
    wr_access && opt_hit[3] && !pwdata_i[RADDR_BIT] && pwdata_i[INPUT_SEL]
    |=> in_mode[3][$past(pwdata_i[PIN_HI:PIN_LO])] == $past(pwdata_i[MODE_LO+1:MODE_LO]))
    else $error("Port 3 input mode not stored");

  a_raddr_keeps_pins: assert property (@(posedge clk_i) disable iff (rst_i)
    wr_access && |opt_hit && pwdata_i[RADDR_BIT] |=> $stable(out_mode) && $stable(in_mode))
    else $error("Read address write changed modes");

  a_reset_modes: assert property (@(posedge clk_i)
    rst_i |=> out_mode == '0 && in_mode == '0)
    else $error("Modes not cleared by reset");

  a_unmapped_no_dir: assert property (@(posedge clk_i) disable iff (rst_i)
    wr_access && !any_hit |=> $stable(dir))
    else $error("Unmapped write changed direction");

  a_unmapped_no_mode: assert property (@(posedge clk_i) disable iff (rst_i)
    wr_access && !any_hit |=> $stable(out_mode) && $stable(in_mode))
    else $error("Unmapped write changed modes");

  a_opt_wr_no_dir: assert property (@(posedge clk_i) disable iff (rst_i)
    wr_access && |opt_hit |=> $stable(dir))
    else $error("Option write changed direction");
endmodule
`default_nettype wire

// file: dv/ppc_apb_master.sv
// Processor side bus master model issuing single register transfers
`timescale 1ns/100ps
`default_nettype none
module ppc_apb_master (
  input  wire logic                  clk_i,
  input  wire logic                  pready_i,
  input  wire logic                  pslverr_i,
  input  wire logic [31:0]           prdata_i,
  output logic                       psel_o,
  output logic                       penable_o,
  output logic                       pwrite_o,
  output logic [ppc_pkg::PAW-1:0]    paddr_o,
  output logic [31:0]                pwdata_o
);
  import ppc_pkg::*;

  // ==========================================================================
  // Idle bus
  initial begin
    psel_o    = 1'b0;
    penable_o = 1'b0;
    pwrite_o  = 1'b0;
    paddr_o   = '0;
    pwdata_o  = 32'h0;
  end

  // ==========================================================================
  // One register access per call, one pin per option write
  task automatic xfer(input logic w, input logic [PAW-1:0] a, input logic [31:0] d,
                      output logic [31:0] r, output logic e);
    @(posedge clk_i);
    psel_o    <= 1'b1;
    penable_o <= 1'b0;
    pwrite_o  <= w;
    paddr_o   <= a;
    pwdata_o  <= d;
    @(posedge clk_i);
    penable_o <= 1'b1;
    do @(posedge clk_i); while (pready_i !== 1'b1);
    r = prdata_i;
    e = pslverr_i;
    psel_o    <= 1'b0;
    penable_o <= 1'b0;
  endtask
endmodule
`default_nettype wire

// file: dv/ppc_top_tb_top.sv
// Testbench for the port pin configuration block
`timescale 1ns/100ps
`default_nettype none
module ppc_top_tb_top;
  import ppc_pkg::*;

  // ==========================================================================
  // Clock, reset and design
  logic                      clk_i = 1'b0;
  logic                      rst_i = 1'b1;
  logic                      psel, penable, pwrite, pready, pslverr;
  logic [PAW-1:0]            paddr;
  logic [31:0]               pwdata, prdata;
  logic [NUM_PORTS-1:0][7:0] oe, hd, pu, pd, ib;
  int                        num_errors = 0;
  int                        num_checks = 0;
  int                        cycles     = 0;

  always #5 clk_i = ~clk_i;

  ppc_apb_master i_m (.clk_i(clk_i), .pready_i(pready), .pslverr_i(pslverr),
    .prdata_i(prdata), .psel_o(psel), .penable_o(penable), .pwrite_o(pwrite),
    .paddr_o(paddr), .pwdata_o(pwdata));

  ppc_top i_dut (.clk_i(clk_i), .rst_i(rst_i), .psel_i(psel), .penable_i(penable),
    .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata),
    .pready_o(pready), .pslverr_o(pslverr), .pin_oe_o(oe), .pin_high_drive_o(hd),
    .pin_pull_up_o(pu), .pin_pull_down_o(pd), .pin_in_buf_en_o(ib));

  // ==========================================================================
  // Shared tasks
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic conclude();
    $display("Checks %0d mismatches %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  task automatic wr(input logic [7:0] idx, input logic [31:0] d);
    logic [31:0] r;
    logic        e;
    i_m.xfer(1'b1, PAW'(idx) << 2, d, r, e);
    #1;
  endtask

  task automatic rd(input logic [7:0] idx, output logic [31:0] r);
    logic e;
    i_m.xfer(1'b0, PAW'(idx) << 2, 32'h0, r, e);
    #1;
  endtask

  // ==========================================================================
  // Scenarios
  task automatic test_reset();
    logic [31:0] r;
    for (int p = 0; p < NUM_PORTS; p++) begin
      rd(PORT0_DIRECTION_IDX + 8'(p), r);
      chk("direction reset", r, (p == 3) ? 32'h7f : 32'hff);
      chk("oe reset", 32'(oe[p]), 32'h0);
      chk("input buffer reset", 32'(ib[p]), 32'hff);
      chk("pull drive reset", 32'({pu[p], pd[p], hd[p]}), 32'h0);
    end
    rd(PORT0_PIN_OPTIONS_IDX, r);
    chk("option read reset", r, 32'h0);
    $display("test_reset done");
  endtask

  task automatic test_direction();
    logic [31:0] r;
    wr(PORT2_DIRECTION_IDX, 32'ha5);
    wr(PORT3_DIRECTION_IDX, 32'h00);
    chk("port2 oe", 32'(oe[2]), 32'h5a);
    chk("port3 oe", 32'(oe[3]), 32'h7f);
    rd(PORT2_DIRECTION_IDX, r);
    chk("port2 direction", r, 32'ha5);
    rd(PORT3_DIRECTION_IDX, r);
    chk("port3 direction", r, 32'h00);
    $display("test_direction done");
  endtask

  task automatic test_output();
    logic [31:0] r;
    wr(PORT0_PIN_OPTIONS_IDX, {24'h0, OUT_HIGH, 5'h05});
    chk("high drive", 32'(hd[0]), 32'h20);
    wr(PORT0_PIN_OPTIONS_IDX, 32'h0d);
    rd(PORT0_PIN_OPTIONS_IDX, r);
    chk("output read", r, {24'h0, OUT_HIGH, 5'h0});
    wr(PORT0_PIN_OPTIONS_IDX, 32'hfd);
    chk("latch keeps pins", {hd[0], pu[0], pd[0], ib[0]}, 32'h200000ff);
    rd(PORT0_PIN_OPTIONS_IDX, r);
    chk("input read", r, 32'h0);
    wr(PORT0_PIN_OPTIONS_IDX, {24'h0, OUT_NORMAL, 5'h05});
    chk("normal drive", 32'(hd[0]), 32'h0);
    $display("test_output done");
  endtask

  task automatic test_input();
    logic [31:0] r;
    for (int c = 0; c < 4; c++) begin
      wr(PORT1_PIN_OPTIONS_IDX, (32'(c) << 5) | 32'h12);
      chk("pull up", 32'(pu[1]), (c == 2) ? 32'h04 : 32'h0);
      chk("pull down", 32'(pd[1]), (c == 1) ? 32'h04 : 32'h0);
      chk("input buffer", 32'(ib[1]), (c == 3) ? 32'hfb : 32'hff);
      chk("drive untouched", 32'(hd[1]), 32'h0);
    end
    wr(PORT1_PIN_OPTIONS_IDX, 32'h1a);
    rd(PORT1_PIN_OPTIONS_IDX, r);
    chk("input mode read", r, 32'h60);
    $display("test_input done");
  endtask

  task automatic test_unmapped();
    logic [31:0] r;
    logic        e;
    i_m.xfer(1'b1, 12'h000, 32'h00, r, e);
    chk("unmapped write error", 32'(e), 32'h1);
    i_m.xfer(1'b0, 12'h000, 32'h0, r, e);
    chk("unmapped read", r, 32'h0);
    $display("test_unmapped done");
  endtask

  // ==========================================================================
  // Sequence and timeout
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 5000) begin
      num_errors++;
      conclude();
    end
  end

  initial begin
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    test_reset();
    test_direction();
    test_output();
    test_input();
    test_unmapped();
    conclude();
  end
endmodule
`default_nettype wire

// file: inc/ppc_opt_if.sv
// Interface carrying an option write from the bus decoder to one port option store
`timescale 1ns/100ps
`default_nettype none
interface ppc_opt_if;
  logic       wr;
  logic [7:0] wdata;
  logic [2:0] rdata;

  modport ctrl  (output wr, output wdata, input rdata);
  modport store (input wr, input wdata, output rdata);
endinterface
`default_nettype wire

// file: inc/ppc_pkg.sv
// Package with register map, field layout and reset values of the port pin configuration block
package ppc_pkg;

  // ==========================================================================
  // Register indices (printed offsets are not word aligned)
  localparam logic [7:0] PORT0_DIRECTION_IDX   = 8'h93;
  localparam logic [7:0] PORT1_DIRECTION_IDX   = 8'h94;
  localparam logic [7:0] PORT2_DIRECTION_IDX   = 8'h95;
  localparam logic [7:0] PORT3_DIRECTION_IDX   = 8'h96;
  localparam logic [7:0] PORT0_PIN_OPTIONS_IDX = 8'h9e;
  localparam logic [7:0] PORT1_PIN_OPTIONS_IDX = 8'h9f;
  localparam logic [7:0] PORT2_PIN_OPTIONS_IDX = 8'ha0;
  localparam logic [7:0] PORT3_PIN_OPTIONS_IDX = 8'ha1;

  // ==========================================================================
  // Geometry
  localparam int NUM_PORTS = 4;
  localparam int PAW       = 12;

  // ==========================================================================
  // Option register fields
  localparam int MODE_HI   = 7;
  localparam int MODE_LO   = 5;
  localparam int INPUT_SEL = 4;
  localparam int RADDR_BIT = 3;
  localparam int PIN_HI    = 2;
  localparam int PIN_LO    = 0;
  localparam int P3_RSVD   = 7;

  // ==========================================================================
  // Mode codes
  localparam logic [2:0] OUT_NORMAL   = 3'h0;
  localparam logic [2:0] OUT_HIGH     = 3'h3;
  localparam logic [1:0] IN_NO_PULL   = 2'h0;
  localparam logic [1:0] IN_PULL_DOWN = 2'h1;
  localparam logic [1:0] IN_PULL_UP   = 2'h2;
  localparam logic [1:0] IN_BUF_OFF   = 2'h3;

  // ==========================================================================
  // Reset values
  localparam logic [7:0] DIR_RESET  = 8'hff;
  localparam logic [2:0] MODE_RESET = 3'h0;
  localparam logic [2:0] PIN_RESET  = 3'h0;

  // Pin configuration view for one port
  typedef struct packed {
    logic [7:0]      out_high;
    logic [7:0][1:0] in_mode;
  } ppc_pin_cfg_t;

endpackage
